// File: spt_defines.svh
// register offsets, field positions, reset values and timing counts of the protection block
`ifndef SPT_DEFINES_SVH
`define SPT_DEFINES_SVH

`define SPT_CLK_HZ 40000000
`define SPT_CLAMP_MS 4
`define SPT_OFF_MS 128
`define SPT_CLAMP_CYC (`SPT_CLK_HZ / 1000 * `SPT_CLAMP_MS)
`define SPT_OFF_CYC (`SPT_CLK_HZ / 1000 * `SPT_OFF_MS)
`define SPT_TONE_HZ 22000
`define SPT_TONE_HALF_CYC (`SPT_CLK_HZ / (2 * `SPT_TONE_HZ))

`define SPT_ADDR_CTRL1 8'h00
`define SPT_ADDR_CTRL2 8'h01
`define SPT_ADDR_STAT 8'h02
`define SPT_ADDR_IRQ_MASK 8'h03

`define SPT_CTRL1_RST 8'h08
`define SPT_CTRL2_RST 8'h09
`define SPT_IRQ_MASK_RST 8'h00

`define SPT_C1_BUS_CTL 7
`define SPT_C1_GATE 5
`define SPT_C1_SRC 4
`define SPT_C1_OUT_EN 3
`define SPT_C1_VHI 2
`define SPT_C1_VSEL_HI 2
`define SPT_C2_LIM_EXT 0
`define SPT_C2_LIM_HI 2
`define SPT_C2_LIM_LO 1

`define SPT_ST_T125 6
`define SPT_ST_LDO_ON 5
`define SPT_ST_THERM 3
`define SPT_ST_OVC 2
`define SPT_ST_CABLE 1
`define SPT_ST_VGOOD 0

`endif

// File: spt_pkg.sv
// types shared by the protection block
package spt_pkg;
	typedef enum logic [1:0] {
		SPT_RUN = 2'b00,
		SPT_CLAMP = 2'b01,
		SPT_OFF = 2'b11
	} spt_ocp_e;
endpackage : spt_pkg

// File: spt_tone_gen.sv
// internal 22 kHz tone generator, square wave from a cycle divider
`timescale 1ns/1ps
`include "spt_defines.svh"
module spt_tone_gen #(
	parameter int HALF_CYC = `SPT_TONE_HALF_CYC
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// control
	input wire logic run,
	// tone
	output logic tone
);
	logic [15:0] cnt_q;
	logic tone_q;
	wire wrap = (cnt_q == 16'(HALF_CYC - 1));

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= 16'h0000;
			tone_q <= 1'b0;
		end else if (!run) begin
			cnt_q <= 16'h0000;
			tone_q <= 1'b0;
		end else begin
			cnt_q <= wrap ? 16'h0000 : cnt_q + 16'h0001;
			tone_q <= wrap ? ~tone_q : tone_q;
		end
	end
	assign tone = tone_q;
endmodule : spt_tone_gen

// File: spt_protect.sv
// overcurrent hiccup, thermal shutdown, fault latch, tone select and register port
// What this block does
// (RULE1) on overcurrent, clamp current at the limit for 4 ms first
// (RULE2) if overcurrent persists, shut down 128 ms, retry, repeat while fault stays
// (RULE3) shut output above 160 C, re-enable only below 140 C
// (RULE4) register port and status stay live during overcurrent or thermal shutdown
// (RULE5) entering overcurrent or thermal shutdown pulls fault pin low and holds it
// (RULE6) without bus control, enable pin off-then-on releases the fault pin
// (RULE7) with bus control, reading the status register releases the fault pin
// (RULE8) tone comes from external tone input or gated internal generator
// (RULE9) four tone setups from source choice and gate, bus or not
// (RULE10) current limit may come from a register instead of the resistor
// (RULE11) an 18 V to 13 V change enables the output pull-down during transition
// (RULE12) source select bit one picks internal tone, zero picks external input
// (RULE13) tone gate bit passes or blocks the selected tone
// (RULE14) only overcurrent and thermal flags latch; other flags track live
// (RULE15) clamp and off intervals counted on the clock, restarted per new episode
// (RULE16) a fault still present at release re-asserts the fault pin at once
`timescale 1ns/1ps
`include "spt_defines.svh"
module spt_protect #(
	parameter int CLAMP_CYC = `SPT_CLAMP_CYC,
	parameter int OFF_CYC = `SPT_OFF_CYC,
	parameter int TONE_HALF = `SPT_TONE_HALF_CYC
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// analog sense inputs
	input wire logic over_current,
	input wire logic temp_above_160,
	input wire logic temp_above_140,
	input wire logic temp_above_125,
	input wire logic cable_good,
	input wire logic vout_good,
	input wire logic ramp_done,
	// host pins
	input wire logic enable_pin,
	input wire logic external_tone_input,
	input wire logic tone_gate_pin,
	output logic fault_o,
	output logic fault_oe,
	output logic irq,
	// analog controls
	output logic converter_on,
	output logic current_clamp,
	output logic limit_from_reg,
	output logic [1:0] limit_code,
	output logic [2:0] volt_sel,
	output logic pull_down_en,
	output logic tone_out
);
	logic [7:0] ctrl1_q;
	logic [7:0] ctrl2_q;
	logic [7:0] mask_q;
	logic [7:0] rdata_q;
	logic ovc_flag_q;
	logic therm_flag_q;
	logic therm_sd_q;
	logic fault_q;
	logic en_prev_q;
	logic en_off_seen_q;
	logic vhi_prev_q;
	logic pull_q;
	logic [31:0] tmr_q;
	logic [31:0] tmr_d;
	spt_pkg::spt_ocp_e ocp_q;
	spt_pkg::spt_ocp_e ocp_d;
	logic int_tone;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	// decode
	wire wr_c1 = reg_wr && hit(reg_addr, `SPT_ADDR_CTRL1);
	wire wr_c2 = reg_wr && hit(reg_addr, `SPT_ADDR_CTRL2);
	wire wr_msk = reg_wr && hit(reg_addr, `SPT_ADDR_IRQ_MASK);
	wire rd_st = reg_rd && hit(reg_addr, `SPT_ADDR_STAT);
	wire bus_ctl = ctrl1_q[`SPT_C1_BUS_CTL];
	wire out_en = bus_ctl ? ctrl1_q[`SPT_C1_OUT_EN] : enable_pin;

	// overcurrent hiccup sequencer
	wire tmr_end = (tmr_q == 32'(0));
	wire ovc_trip = (ocp_q == spt_pkg::SPT_CLAMP) && over_current && tmr_end;
	always_comb begin
		ocp_d = ocp_q;
		tmr_d = tmr_end ? 32'(0) : tmr_q - 32'(1);
		case (ocp_q)
			spt_pkg::SPT_RUN: begin
				if (over_current && out_en && !therm_sd_q) begin
					ocp_d = spt_pkg::SPT_CLAMP; // RULE1
					tmr_d = 32'(CLAMP_CYC - 1); // RULE15
				end
			end
			spt_pkg::SPT_CLAMP: begin
				if (!over_current) begin
					ocp_d = spt_pkg::SPT_RUN;
				end else if (tmr_end) begin
					ocp_d = spt_pkg::SPT_OFF; // RULE2
					tmr_d = 32'(OFF_CYC - 1); // RULE15
				end
			end
			spt_pkg::SPT_OFF: begin
				if (tmr_end) begin
					ocp_d = spt_pkg::SPT_RUN; // RULE2
				end
			end
			default: begin
				ocp_d = spt_pkg::SPT_RUN;
			end
		endcase
	end

	// thermal hysteresis: trip above upper, recover only below lower
	wire therm_d = temp_above_160 ? 1'b1 : (temp_above_140 ? therm_sd_q : 1'b0); // RULE3

	// fault releases: enable recycle without bus, status read with bus
	wire en_rise = enable_pin && !en_prev_q;
	wire rel_en = !bus_ctl && en_rise && en_off_seen_q; // RULE6
	wire rel_rd = bus_ctl && rd_st; // RULE7
	wire release_ev = rel_en || rel_rd;
	wire therm_enter = therm_d && !therm_sd_q;
	// set wins over release; a condition still present re-latches
	wire ovc_set = ovc_trip || (ocp_q == spt_pkg::SPT_OFF); // RULE16
	wire therm_set = therm_enter || therm_sd_q; // RULE16
	wire ovc_flag_d = ovc_trip || (release_ev ? ovc_set : ovc_flag_q); // RULE5
	wire therm_flag_d = therm_enter || (release_ev ? therm_set : therm_flag_q); // RULE5

	// status view: only two flags latch, the rest are live
	wire [7:0] status = {1'b0, temp_above_125, converter_on && out_en, 1'b0,
		therm_flag_q, ovc_flag_q, cable_good, vout_good}; // RULE14
	wire [7:0] rd_mux = hit(reg_addr, `SPT_ADDR_CTRL1) ? ctrl1_q :
		hit(reg_addr, `SPT_ADDR_CTRL2) ? ctrl2_q :
		hit(reg_addr, `SPT_ADDR_STAT) ? status :
		hit(reg_addr, `SPT_ADDR_IRQ_MASK) ? mask_q : 8'h00;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl1_q <= `SPT_CTRL1_RST;
			ctrl2_q <= `SPT_CTRL2_RST;
			mask_q <= `SPT_IRQ_MASK_RST;
		end else begin
			if (wr_c1)
				ctrl1_q <= reg_wdata;
			if (wr_c2)
				ctrl2_q <= reg_wdata;
			if (wr_msk)
				mask_q <= reg_wdata;
		end
	end

	// register port is never gated by protection state
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			rdata_q <= 8'h00;
		else
			rdata_q <= reg_rd ? rd_mux : 8'h00; // RULE4
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ocp_q <= spt_pkg::SPT_RUN;
			tmr_q <= 32'(0);
			therm_sd_q <= 1'b0;
			ovc_flag_q <= 1'b0;
			therm_flag_q <= 1'b0;
		end else begin
			ocp_q <= ocp_d;
			tmr_q <= tmr_d;
			therm_sd_q <= therm_d;
			ovc_flag_q <= ovc_flag_d;
			therm_flag_q <= therm_flag_d;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			en_prev_q <= 1'b0;
			en_off_seen_q <= 1'b0;
			fault_q <= 1'b0;
		end else begin
			en_prev_q <= enable_pin;
			en_off_seen_q <= !enable_pin ? 1'b1 : (en_rise ? 1'b0 : en_off_seen_q);
			fault_q <= ovc_flag_d || therm_flag_d; // RULE5
		end
	end

	// open drain fault pin: drive low only while latched
	assign fault_o = 1'b0;
	assign fault_oe = fault_q; // RULE5
	assign irq = |(status & mask_q);

	assign converter_on = out_en && !therm_sd_q && (ocp_q != spt_pkg::SPT_OFF); // RULE3
	assign current_clamp = (ocp_q == spt_pkg::SPT_CLAMP); // RULE1
	assign limit_from_reg = !ctrl2_q[`SPT_C2_LIM_EXT]; // RULE10
	assign limit_code = ctrl2_q[`SPT_C2_LIM_HI:`SPT_C2_LIM_LO]; // RULE10
	assign volt_sel = ctrl1_q[`SPT_C1_VSEL_HI:0];

	// pull-down from a high-to-low setting change until the ramp settles
	wire vhi = ctrl1_q[`SPT_C1_VHI];
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			vhi_prev_q <= 1'b0;
			pull_q <= 1'b0;
		end else begin
			vhi_prev_q <= vhi;
			if (vhi_prev_q && !vhi)
				pull_q <= 1'b1; // RULE11
			else if (ramp_done || vhi)
				pull_q <= 1'b0;
		end
	end
	assign pull_down_en = pull_q;

	// tone source: without bus control the external input carries the tone itself while the gate pin is low
	wire src_int = bus_ctl ? ctrl1_q[`SPT_C1_SRC] : 1'b0; // RULE12
	wire gate = bus_ctl ? ctrl1_q[`SPT_C1_GATE] : tone_gate_pin; // RULE13
	// four setups: bus ext/int gated, or pins with external clock or level gate
	wire ext_level_mode = !bus_ctl && tone_gate_pin; // RULE9
	spt_tone_gen #(
		.HALF_CYC(TONE_HALF)
	) u_tone (
		.mclk(mclk),
		.reset_n(reset_n),
		.run(gate && (src_int || ext_level_mode)),
		.tone(int_tone)
	);
	wire tone_sel = (src_int || (ext_level_mode && external_tone_input)) ?
		int_tone : external_tone_input; // RULE8
	logic tone_q;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			tone_q <= 1'b0;
		else
			tone_q <= (bus_ctl ? gate : 1'b1) && converter_on && tone_sel; // RULE13
	end
	assign tone_out = tone_q;
	assign reg_rdata = rdata_q;

	// assertions
	sequence clamp_start_s;
		ocp_q == spt_pkg::SPT_RUN && over_current && out_en && !therm_sd_q;
	endsequence
	clamp_enter_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE1
		clamp_start_s |=> current_clamp && tmr_q == 32'(CLAMP_CYC - 1))
		else $error("clamp window did not start");
	off_enter_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE2
		ovc_trip |=> !converter_on && tmr_q == 32'(OFF_CYC - 1))
		else $error("hiccup off did not start");
	off_exit_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE15
		ocp_q == spt_pkg::SPT_OFF && tmr_end |=> ocp_q == spt_pkg::SPT_RUN)
		else $error("hiccup off did not end");
	therm_hyst_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE3
		therm_sd_q && temp_above_140 |=> therm_sd_q)
		else $error("thermal released above lower threshold");
	therm_off_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE3
		temp_above_160 |=> !converter_on)
		else $error("output on above trip");
	fault_drive_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE5
		ovc_trip || therm_enter |=> fault_oe ##1 fault_oe)
		else $error("fault pin not held low");
	rd_release_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE7
		rel_rd && !ovc_set && !therm_set && !ovc_trip && !therm_enter |=> !fault_oe)
		else $error("status read did not release fault");
	read_live_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE4
		reg_rd && hit(reg_addr, `SPT_ADDR_CTRL1) |=> reg_rdata == $past(ctrl1_q))
		else $error("register read lost during protection");
	pull_set_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE11
		$fell(vhi_prev_q) |-> pull_down_en)
		else $error("pull-down not enabled on downward step");

	sequence off_end_s;
		ocp_q == spt_pkg::SPT_OFF && tmr_end;
	endsequence
	sequence retry_cond_s;
		over_current && out_en && !therm_sd_q;
	endsequence
	sequence ext_path_s;
		bus_ctl && !ctrl1_q[`SPT_C1_SRC] && ctrl1_q[`SPT_C1_GATE] && converter_on;
	endsequence
	sequence int_path_s;
		bus_ctl && ctrl1_q[`SPT_C1_SRC] && ctrl1_q[`SPT_C1_GATE] && converter_on;
	endsequence

	// hiccup timing
	clamp_hold_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE1
		ocp_q == spt_pkg::SPT_CLAMP && over_current && !tmr_end |=> current_clamp)
		else $error("clamp window cut short");
	clamp_quit_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE15
		ocp_q == spt_pkg::SPT_CLAMP && !over_current |=> !current_clamp)
		else $error("clamp kept after short cleared");
	off_hold_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE2
		ocp_q == spt_pkg::SPT_OFF && !tmr_end |=> ocp_q == spt_pkg::SPT_OFF && !converter_on)
		else $error("hiccup off ended early");
	hiccup_retry_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE2
		off_end_s ##1 retry_cond_s |=> current_clamp)
		else $error("retry did not clamp again");

	// fault latch: held until a release, re-latched while the cause remains
	fault_hold_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE5
		fault_oe && !release_ev |=> fault_oe)
		else $error("fault pin let go without release");
	enable_release_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE6
		rel_en && !ovc_set && !therm_set |=> !fault_oe)
		else $error("enable recycle did not release fault");
	fault_relatch_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE16
		release_ev && (ovc_set || therm_set) |=> fault_oe)
		else $error("fault released while cause present");
	therm_recover_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE3
		!temp_above_160 && !temp_above_140 |=> !therm_sd_q)
		else $error("thermal shutdown kept below lower threshold");

	// tone paths, one cycle behind the selected source
	ext_pass_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE12
		ext_path_s |=> tone_out == $past(external_tone_input))
		else $error("external tone not passed");
	int_pick_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE12
		int_path_s |=> tone_out == $past(int_tone))
		else $error("internal tone not passed");
	gate_block_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE13
		bus_ctl && !ctrl1_q[`SPT_C1_GATE] |=> !tone_out)
		else $error("tone passed with gate off");
	pin_level_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE9
		ext_level_mode && external_tone_input && converter_on |=> tone_out == $past(int_tone))
		else $error("level mode did not pass internal tone");
	pin_pass_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE9
		!bus_ctl && !tone_gate_pin && converter_on |=> tone_out == $past(external_tone_input))
		else $error("pin mode did not pass external clock");

	// live status bits and the pull-down release
	status_live_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE14
		rd_st |=> reg_rdata[6] == $past(temp_above_125) &&
		reg_rdata[1] == $past(cable_good) && reg_rdata[0] == $past(vout_good))
		else $error("live status bit not current");
	pull_clear_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE11
		pull_down_en && ramp_done && !(vhi_prev_q && !vhi) |=> !pull_down_en)
		else $error("pull-down kept after ramp settled");
endmodule : spt_protect

// File: spt_host_model.sv
// host side model: enable pin, external tone source and pulled-up fault line
`timescale 1ns/1ps
module spt_host_model #(
	parameter int EXT_HALF = 7
) (
	// clock
	input wire logic mclk,
	// commands from the bench
	input wire logic en_cmd,
	input wire logic [1:0] ext_mode,
	// pins
	input wire logic fault_o,
	input wire logic fault_oe,
	output logic enable_pin,
	output logic external_tone_input,
	output logic fault_line
);
	int cnt_q = 0;
	logic clk_q = 1'b0;
	// pull-up holds the line high whenever the device lets go
	assign fault_line = fault_oe ? fault_o : 1'b1;
	assign enable_pin = en_cmd;
	// mode 2 runs the tone clock, modes 0 and 1 hold a level so no stale edge leaks through
	assign external_tone_input = (ext_mode == 2'h2) ? clk_q : ext_mode[0];
	always_ff @(posedge mclk) begin
		cnt_q <= (cnt_q == EXT_HALF - 1) ? 0 : cnt_q + 1;
		if (cnt_q == EXT_HALF - 1) clk_q <= ~clk_q;
	end
endmodule : spt_host_model

// File: test_supply_protection_tone_control.sv
// testbench for the protection and tone control block
`timescale 1ns/1ps
module test_supply_protection_tone_control;
	localparam int CLAMP = 20;
	localparam int OFF = 50;
	logic mclk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, over_current = 0, temp_above_160 = 0;
	logic temp_above_140 = 0, temp_above_125 = 0, cable_good = 0, vout_good = 0, ramp_done = 0;
	logic tone_gate_pin = 0, en_cmd = 1, fault_o, fault_oe, irq, converter_on, current_clamp;
	logic limit_from_reg, pull_down_en, tone_out;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd;
	logic [1:0] ext_mode = 2'h0, limit_code;
	logic [2:0] volt_sel;
	wire enable_pin, external_tone_input, fault_line;
	int err_count = 0, samples_checked = 0, n;
	spt_protect #(.CLAMP_CYC(CLAMP), .OFF_CYC(OFF), .TONE_HALF(4)) dut (.mclk(mclk),
		.reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .over_current(over_current),
		.temp_above_160(temp_above_160), .temp_above_140(temp_above_140),
		.temp_above_125(temp_above_125), .cable_good(cable_good), .vout_good(vout_good),
		.ramp_done(ramp_done), .enable_pin(enable_pin), .external_tone_input(external_tone_input),
		.tone_gate_pin(tone_gate_pin), .fault_o(fault_o), .fault_oe(fault_oe), .irq(irq),
		.converter_on(converter_on), .current_clamp(current_clamp),
		.limit_from_reg(limit_from_reg), .limit_code(limit_code), .volt_sel(volt_sel),
		.pull_down_en(pull_down_en), .tone_out(tone_out));
	spt_host_model host (.mclk(mclk), .en_cmd(en_cmd), .ext_mode(ext_mode), .fault_o(fault_o),
		.fault_oe(fault_oe), .enable_pin(enable_pin),
		.external_tone_input(external_tone_input), .fault_line(fault_line));
	always #12.5 mclk = ~mclk;
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : reg_write
	task automatic reg_read(input logic [7:0] a);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 rd = reg_rdata;
	endtask : reg_read
	task automatic settle(input int c);
		repeat (c) @(posedge mclk);
		#1;
	endtask : settle
	task automatic tone_try(input logic [7:0] c1, input logic gp, input logic [1:0] em,
		input logic exp);
		logic last;
		reg_write(8'h00, c1);
		tone_gate_pin <= gp;
		ext_mode <= em;
		settle(6);
		n = 0;
		last = tone_out;
		repeat (60) begin
			settle(1);
			if (tone_out !== last) n++;
			last = tone_out;
		end
		chk("tone toggles", {7'h00, exp}, {7'h00, n > 0});
	endtask : tone_try
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish
	initial begin
		#(25ns * 20000);
		err_count++;
		tally_and_finish();
	end
	initial begin
		repeat (4) @(posedge mclk);
		reset_n <= 1'b1;
		reg_read(8'h00); chk("ctrl1 reset", 8'h08, rd);
		reg_read(8'h01); chk("ctrl2 reset", 8'h09, rd);
		reg_read(8'h03); chk("mask reset", 8'h00, rd);
		reg_write(8'h05, 8'hFF); reg_read(8'h05); chk("unmapped", 8'h00, rd);
		reg_write(8'h01, 8'h04); settle(2);
		chk("limit source", 8'h01, {7'h00, limit_from_reg});
		chk("limit code", 8'h02, {6'h00, limit_code});
		$display("test registers done");
		// hiccup under a persistent short, bus control on
		reg_write(8'h00, 8'h88);
		over_current <= 1'b1;
		n = 0;
		while (current_clamp !== 1'b1 && n < 5) begin settle(1); n++; end
		chk("clamp on", 8'h01, {7'h00, current_clamp & converter_on});
		n = 0;
		while (current_clamp === 1'b1 && n < 200) begin settle(1); n++; end
		chk("clamp span", 8'h01, {7'h00, n >= CLAMP - 1 && n <= CLAMP + 2});
		settle(1);
		chk("fault low", 8'h00, {7'h00, fault_line});
		n = 0;
		while (converter_on !== 1'b1 && n < 200) begin settle(1); n++; end
		chk("off span", 8'h01, {7'h00, n >= OFF - 2 && n <= OFF + 2});
		settle(2);
		chk("retry clamp", 8'h01, {7'h00, current_clamp});
		@(posedge mclk);
		over_current <= 1'b0;
		cable_good <= 1'b1;
		settle(4);
		reg_read(8'h02); chk("status ovc", 8'h06, rd & 8'h0E);
		settle(2);
		chk("fault freed", 8'h01, {7'h00, fault_line});
		@(posedge mclk);
		cable_good <= 1'b0;
		temp_above_125 <= 1'b1;
		reg_read(8'h02); chk("status live", 8'h60, rd & 8'h67);
		$display("test hiccup done");
		// thermal episode with a read while still hot
		reg_write(8'h03, 8'h08);
		temp_above_160 <= 1'b1;
		temp_above_140 <= 1'b1;
		settle(3);
		chk("hot off", 8'h00, {7'h00, converter_on});
		chk("irq on", 8'h01, {7'h00, irq});
		reg_read(8'h00); chk("ctrl1 live", 8'h88, rd);
		reg_read(8'h02); chk("status hot", 8'h08, rd & 8'h0C);
		settle(2);
		chk("fault held", 8'h00, {7'h00, fault_line});
		reg_write(8'h03, 8'h00); settle(1);
		chk("irq masked", 8'h00, {7'h00, irq});
		@(posedge mclk);
		temp_above_160 <= 1'b0;
		settle(3);
		chk("hysteresis", 8'h00, {7'h00, converter_on});
		@(posedge mclk);
		temp_above_140 <= 1'b0;
		settle(3);
		chk("cool on", 8'h01, {7'h00, converter_on});
		reg_read(8'h02); settle(2);
		chk("hot freed", 8'h01, {7'h00, fault_line});
		$display("test thermal done");
		// pin control: enable recycle frees the line
		reg_write(8'h00, 8'h08);
		temp_above_160 <= 1'b1;
		temp_above_140 <= 1'b1;
		settle(3);
		@(posedge mclk);
		temp_above_160 <= 1'b0;
		temp_above_140 <= 1'b0;
		settle(3);
		chk("pin fault", 8'h00, {7'h00, fault_line});
		@(posedge mclk);
		en_cmd <= 1'b0;
		settle(3);
		@(posedge mclk);
		en_cmd <= 1'b1;
		settle(3);
		chk("recycle freed", 8'h01, {7'h00, fault_line});
		$display("test enable recycle done");
		reg_write(8'h00, 8'h8C);
		settle(1);
		chk("volt sel", 8'h04, {5'h00, volt_sel});
		reg_write(8'h00, 8'h88);
		settle(2);
		chk("pull down on", 8'h01, {7'h00, pull_down_en});
		@(posedge mclk);
		ramp_done <= 1'b1;
		settle(3);
		chk("pull down off", 8'h00, {7'h00, pull_down_en});
		@(posedge mclk);
		ramp_done <= 1'b0;
		$display("test pull down done");
		tone_try(8'hA8, 1'b0, 2'h0, 1'b0);
		tone_try(8'hA8, 1'b0, 2'h2, 1'b1);
		tone_try(8'hB8, 1'b0, 2'h0, 1'b1);
		tone_try(8'h98, 1'b0, 2'h2, 1'b0);
		tone_try(8'h08, 1'b1, 2'h1, 1'b1);
		tone_try(8'h08, 1'b0, 2'h2, 1'b1);
		tone_try(8'h08, 1'b1, 2'h0, 1'b0);
		$display("test tone done");
		tally_and_finish();
	end
endmodule : test_supply_protection_tone_control
